//--- core_sfr.v
// Core special-function registers: accumulator, flags, program counter
// low byte, table read registers and the indirect port, on APB.
// Assumes the program word input answers the lookup pointer combinationally.
`timescale 1ns/1ps
`default_nettype none
`include "core_sfr_defines.vh"
module core_sfr (
    // Clock and reset
    input  wire        i_core_clk,
    input  wire        i_rst,
    // APB slave
    input  wire        i_psel,
    input  wire        i_penable,
    input  wire        i_pwrite,
    input  wire [31:0] i_paddr,
    input  wire [31:0] i_pwdata,
    output wire        o_pready,
    output reg  [31:0] o_prdata,
    output wire        o_pslverr,
    // Program memory table port
    input  wire [15:0] i_prog_word,
    output wire [7:0]  o_table_addr,
    // Program counter
    output wire [15:0] o_pc,
    output wire        o_dummy_cycle
);
    localparam ST_IDLE = 2'h0;
    localparam ST_RAM  = 2'h1;
    localparam ST_DONE = 2'h2;

    reg  [7:0]  working_reg;
    reg  [7:0]  indirect_pointer;
    reg  [7:0]  lookup_pointer;
    reg  [7:0]  lookup_high_byte;
    reg  [7:0]  table_low;
    reg  [7:0]  pc_high;
    reg  [7:0]  prog_ptr_low;
    reg  [3:0]  arith_flags;
    reg         halted_flag;
    reg         dog_expiry_flag;
    reg         dummy;
    reg  [7:0]  op_arg;
    reg  [1:0]  state;
    reg  [7:0]  rd_word;

    wire        setup   = i_psel & ~i_penable;
    wire        access  = i_psel & i_penable;
    wire [7:0]  word    = i_paddr[9:2];
    wire        wr_done = access & o_pready & i_pwrite;
    wire        rd_ram  = ~i_pwrite & (word == `ADDR_RAM_DATA);

    // Indirect RAM reads wait two cycles so the registered port has settled
    assign o_pready  = ~(access & rd_ram) | (state == ST_DONE);
    assign o_pslverr = 1'b0;

    wire [7:0] core_flags = {2'b00, dog_expiry_flag, halted_flag,
                             arith_flags};

    // ALU
    wire        op_go = wr_done & (word == `ADDR_OP_CTRL);
    wire [3:0]  op    = op_go ? i_pwdata[3:0] : `OP_NONE;
    wire [7:0]  alu_result;
    wire [3:0]  alu_flags;
    wire        alu_writes;
    alu8 u_alu (
        .i_op     (op),
        .i_a      (working_reg),
        .i_b      (op_arg),
        .i_flags  (arith_flags),
        .o_result (alu_result),
        .o_flags  (alu_flags),
        .o_writes (alu_writes)
    );

    // Data memory behind the indirect pointer
    wire       ram_we = wr_done & (word == `ADDR_RAM_DATA);
    wire [7:0] ram_rdata;
    data_ram u_ram (
        .i_core_clk (i_core_clk),
        .i_we       (ram_we),
        .i_addr     (indirect_pointer[`RAM_AW-1:0]),
        .i_wdata    (i_pwdata[7:0]),
        .o_rdata    (ram_rdata)
    );

    assign o_table_addr  = lookup_pointer;
    assign o_pc          = {pc_high, prog_ptr_low};
    assign o_dummy_cycle = dummy;

    always @(posedge i_core_clk or posedge i_rst) begin
        if (i_rst) begin
            state <= ST_IDLE;
        end else begin
            case (state)
                ST_IDLE: if (access & rd_ram) state <= ST_RAM;
                ST_RAM:  state <= ST_DONE;
                ST_DONE: state <= ST_IDLE;
                default: state <= ST_IDLE;
            endcase
        end
    end

    // Arithmetic flags have no reset value in the device; zero keeps
    // simulation free of unknowns without changing any defined behaviour.
    always @(posedge i_core_clk or posedge i_rst) begin
        if (i_rst) begin
            working_reg      <= 8'h00;
            indirect_pointer <= 8'h00;
            lookup_pointer   <= 8'h00;
            lookup_high_byte <= 8'h00;
            table_low        <= 8'h00;
            pc_high          <= 8'h00;
            prog_ptr_low     <= 8'h00;
            arith_flags      <= 4'h0;
            halted_flag      <= 1'b0;
            dog_expiry_flag  <= 1'b0;
            dummy            <= 1'b0;
            op_arg           <= 8'h00;
        end else begin
            dummy <= 1'b0;
            if (op_go) begin
                if (alu_writes) begin
                    working_reg <= alu_result;
                end
                arith_flags <= alu_flags;
                case (op)
                    `OP_HALT: begin
                        halted_flag     <= 1'b1;
                        dog_expiry_flag <= 1'b0;
                    end
                    `OP_CLRWDT: begin
                        halted_flag     <= 1'b0;
                        dog_expiry_flag <= 1'b0;
                    end
                    `OP_TIMEOUT: dog_expiry_flag <= 1'b1;
                    `OP_TABRD: begin
                        lookup_high_byte <= i_prog_word[15:8];
                        table_low        <= i_prog_word[7:0];
                        working_reg      <= i_prog_word[7:0];
                    end
                    `OP_INC_PTR: lookup_pointer <= lookup_pointer + 8'h01;
                    `OP_DEC_PTR: lookup_pointer <= lookup_pointer - 8'h01;
                    default: ;
                endcase
            end else if (wr_done) begin
                case (word)
                    `ADDR_INDIRECT_POINTER: indirect_pointer <= i_pwdata[7:0];
                    `ADDR_WORKING_REG:      working_reg <= i_pwdata[7:0];
                    `ADDR_PROG_PTR_LOW: begin
                        prog_ptr_low <= i_pwdata[7:0];
                        dummy        <= 1'b1;
                    end
                    `ADDR_LOOKUP_POINTER:  lookup_pointer <= i_pwdata[7:0];
                    `ADDR_LOOKUP_HIGH_BYTE: lookup_high_byte <= i_pwdata[7:0];
                    `ADDR_CORE_FLAGS:
                        arith_flags <= i_pwdata[3:0];
                    `ADDR_PC_HIGH:         pc_high <= i_pwdata[7:0];
                    `ADDR_OP_ARG:          op_arg <= i_pwdata[7:0];
                    default: ;
                endcase
            end
        end
    end

    // Flags are not stacked by calls or interrupts; this block holds no stack
    // and never saves them on its own.
    always @* begin
        case (word)
            `ADDR_INDIRECT_POINTER: rd_word = indirect_pointer;
            `ADDR_WORKING_REG:      rd_word = working_reg;
            `ADDR_PROG_PTR_LOW:     rd_word = prog_ptr_low;
            `ADDR_LOOKUP_POINTER:   rd_word = lookup_pointer;
            `ADDR_LOOKUP_HIGH_BYTE: rd_word = lookup_high_byte;
            `ADDR_CORE_FLAGS:       rd_word = core_flags;
            `ADDR_PC_HIGH:          rd_word = pc_high;
            `ADDR_OP_ARG:           rd_word = op_arg;
            `ADDR_OP_STATUS:        rd_word = {7'h00, dummy};
            `ADDR_PROG_WORD:        rd_word = table_low;
            `ADDR_RAM_DATA:         rd_word = ram_rdata;
            default:                rd_word = 8'h00;
        endcase
    end

    always @(posedge i_core_clk or posedge i_rst) begin
        if (i_rst) begin
            o_prdata <= 32'h00000000;
        end else if (setup & ~i_pwrite & ~rd_ram) begin
            o_prdata <= {24'h000000, rd_word};
        end else if (state == ST_RAM) begin
            o_prdata <= {24'h000000, ram_rdata};
        end
    end
endmodule // core_sfr
`default_nettype wire

//--- core_sfr_defines.vh
// Constants for the core flags and special function register block.
// Assumes an APB master with 32-bit data; one register per aligned word.
`ifndef CORE_SFR_DEFINES_VH
`define CORE_SFR_DEFINES_VH
`define ADDR_INDIRECT_PORT     8'h00
`define ADDR_INDIRECT_POINTER  8'h01
`define ADDR_WORKING_REG       8'h05
`define ADDR_PROG_PTR_LOW      8'h06
`define ADDR_LOOKUP_POINTER    8'h07
`define ADDR_LOOKUP_HIGH_BYTE  8'h08
`define ADDR_CORE_FLAGS        8'h0A
`define ADDR_PC_HIGH           8'h40
`define ADDR_OP_CTRL           8'h41
`define ADDR_OP_ARG            8'h42
`define ADDR_OP_STATUS         8'h43
`define ADDR_RAM_DATA          8'h44
`define ADDR_PROG_WORD         8'h45
`define BIT_CARRY              0
`define BIT_HALF               1
`define BIT_ZERO               2
`define BIT_SIGNED             3
`define BIT_HALTED             4
`define BIT_EXPIRY             5
`define OP_NONE                4'h0
`define OP_ADD                 4'h1
`define OP_SUB                 4'h2
`define OP_AND                 4'h3
`define OP_OR                  4'h4
`define OP_XOR                 4'h5
`define OP_RLC                 4'h6
`define OP_RRC                 4'h7
`define OP_HALT                4'h8
`define OP_CLRWDT              4'h9
`define OP_TIMEOUT             4'hA
`define OP_TABRD               4'hB
`define OP_INC_PTR             4'hC
`define OP_DEC_PTR             4'hD
`define OP_LOAD                4'hE
`define RAM_DEPTH              64
`define RAM_AW                 6
`endif

//--- data_ram.v
// Small data memory reached through the indirect pointer.
// Assumes one write or one read per cycle; read data is registered.
`timescale 1ns/1ps
`default_nettype none
`include "core_sfr_defines.vh"
module data_ram (
    // Clock
    input  wire                i_core_clk,
    // Access
    input  wire                i_we,
    input  wire [`RAM_AW-1:0]  i_addr,
    input  wire [7:0]          i_wdata,
    output reg  [7:0]          o_rdata
);
    reg [7:0] mem [0:`RAM_DEPTH-1];
    always @(posedge i_core_clk) begin
        if (i_we) begin
            mem[i_addr] <= i_wdata;
        end
        o_rdata <= mem[i_addr];
    end
endmodule // data_ram
`default_nettype wire

//--- alu8.v
// Combinational 8-bit ALU with flag generation.
// Assumes the caller registers result and flags.
`timescale 1ns/1ps
`default_nettype none
`include "core_sfr_defines.vh"
module alu8 (
    // Operation
    input  wire [3:0] i_op,
    input  wire [7:0] i_a,
    input  wire [7:0] i_b,
    input  wire [3:0] i_flags,
    // Result
    output reg  [7:0] o_result,
    output reg  [3:0] o_flags,
    output reg        o_writes
);
    reg [8:0] sum;
    reg [4:0] low;
    reg [7:0] bsel;
    reg       c7;
    always @* begin
        sum      = 9'h000;
        low      = 5'h00;
        c7       = 1'b0;
        bsel     = (i_op == `OP_SUB) ? ~i_b : i_b;
        o_result = i_a;
        o_flags  = i_flags;
        o_writes = 1'b1;
        case (i_op)
            `OP_ADD, `OP_SUB: begin
                sum = {1'b0, i_a} + {1'b0, bsel}
                      + {8'h00, i_op == `OP_SUB};
                low = {1'b0, i_a[3:0]} + {1'b0, bsel[3:0]}
                      + {4'h0, i_op == `OP_SUB};
                c7  = i_a[7] ^ bsel[7] ^ sum[7];
                o_result = sum[7:0];
                o_flags[`BIT_CARRY]  = sum[8];
                o_flags[`BIT_HALF]   = low[4];
                o_flags[`BIT_SIGNED] = c7 ^ sum[8];
                o_flags[`BIT_ZERO]   = (sum[7:0] == 8'h00);
            end
            `OP_AND, `OP_OR, `OP_XOR: begin
                o_result = (i_op == `OP_AND) ? (i_a & i_b) :
                           (i_op == `OP_OR)  ? (i_a | i_b) : (i_a ^ i_b);
                o_flags[`BIT_ZERO] = (o_result == 8'h00);
            end
            `OP_RLC: begin
                o_result = {i_a[6:0], i_flags[`BIT_CARRY]};
                o_flags[`BIT_CARRY] = i_a[7];
            end
            `OP_RRC: begin
                o_result = {i_flags[`BIT_CARRY], i_a[7:1]};
                o_flags[`BIT_CARRY] = i_a[0];
            end
            `OP_LOAD: begin
                o_result = i_b;
            end
            default: begin
                o_writes = 1'b0;
            end
        endcase
    end
endmodule // alu8
`default_nettype wire

//--- core_sfr_properties.sv
// Checker for the core special-function block, bound to its ports.
// Assumes one clock and byte addresses four times the word index.
`timescale 1ns/1ps
`default_nettype none
module core_sfr_properties (
    // Clock and reset
    input wire logic        i_core_clk,
    input wire logic        i_rst,
    // APB
    input wire logic        i_psel,
    input wire logic        i_penable,
    input wire logic        i_pwrite,
    input wire logic [31:0] i_paddr,
    input wire logic [31:0] i_pwdata,
    input wire logic        o_pready,
    input wire logic [31:0] o_prdata,
    input wire logic        o_pslverr,
    // Table port and program counter
    input wire logic [15:0] i_prog_word,
    input wire logic [7:0]  o_table_addr,
    input wire logic [15:0] o_pc,
    input wire logic        o_dummy_cycle
);
    wire  wr_done  = i_psel & i_penable & o_pready & i_pwrite;
    wire  rd_setup = i_psel & ~i_penable & ~i_pwrite;
    wire  pcl_wr   = wr_done & (i_paddr == 32'h18);
    logic pcl_wr_d;

    always_ff @(posedge i_core_clk or posedge i_rst) begin
        if (i_rst)
            pcl_wr_d <= 1'b0;
        else
            pcl_wr_d <= pcl_wr;
    end

    default clocking cb @(posedge i_core_clk); endclocking
    default disable iff (i_rst);

    pc_jump_a: assert property (
        pcl_wr |=> o_pc[7:0] == $past(i_pwdata[7:0])
            && o_pc[15:8] == $past(o_pc[15:8]))
        else $error("jump left page");
    pc_steady_a: assert property (
        !pcl_wr && !(wr_done && i_paddr == 32'h100) |=> $stable(o_pc))
        else $error("pc moved by itself");
    dummy_pulse_a: assert property (
        pcl_wr |=> o_dummy_cycle ##1 !o_dummy_cycle)
        else $error("no single dummy cycle");
    dummy_cause_a: assert property (
        o_dummy_cycle |-> pcl_wr_d)
        else $error("stray dummy cycle");
    table_ptr_a: assert property (
        wr_done && i_paddr == 32'h1C
            |=> o_table_addr == $past(i_pwdata[7:0]))
        else $error("bad table addr");
    flags_top_a: assert property (
        rd_setup && i_paddr == 32'h28 |=> o_prdata[7:6] == 2'h0)
        else $error("flag top bits set");
    indirect_zero_a: assert property (
        rd_setup && i_paddr == 32'h0 |=> o_prdata == 32'h0)
        else $error("indirect port not zero");
    unused_zero_a: assert property (
        rd_setup && i_paddr == 32'h8 |=> o_prdata == 32'h0)
        else $error("unused place not zero");
    // Only indirect RAM reads wait, and never more than two cycles
    ready_bound_a: assert property (
        i_psel && i_penable |-> ##[0:2] o_pready)
        else $error("ready too late");

    pcl_cov: cover property (pcl_wr);
    wait_cov: cover property (i_psel && i_penable && !o_pready);
    flag_cov: cover property (rd_setup && i_paddr == 32'h28);
endmodule // core_sfr_properties

bind core_sfr core_sfr_properties chk (.i_core_clk, .i_rst, .i_psel,
    .i_penable, .i_pwrite, .i_paddr, .i_pwdata, .o_pready, .o_prdata,
    .o_pslverr, .i_prog_word, .o_table_addr, .o_pc, .o_dummy_cycle);
`default_nettype wire

//--- core_sfr_test.sv
// Self-checking bench for the core special-function block over APB.
// Assumes the design sets its own wait states; program memory is modelled.
`timescale 1ns/1ps
`default_nettype none
`include "core_sfr_defines.vh"
module core_sfr_test;
    logic        i_core_clk  = 1'b0;
    logic        i_rst       = 1'b1;
    logic        i_psel      = 1'b0;
    logic        i_penable   = 1'b0;
    logic        i_pwrite    = 1'b0;
    logic [31:0] i_paddr     = 32'h0;
    logic [31:0] i_pwdata    = 32'h0;
    logic [15:0] i_prog_word;
    wire         o_pready;
    wire  [31:0] o_prdata;
    wire         o_pslverr;
    wire  [7:0]  o_table_addr;
    wire  [15:0] o_pc;
    wire         o_dummy_cycle;
    int          errors      = 0;
    int          comparisons = 0;
    logic [7:0]  q;

    always #5 i_core_clk = ~i_core_clk;
    // Both bytes differ per address so a swapped byte is caught
    assign i_prog_word = {~o_table_addr, o_table_addr};

    core_sfr dut (.i_core_clk, .i_rst, .i_psel, .i_penable, .i_pwrite,
        .i_paddr, .i_pwdata, .o_pready, .o_prdata, .o_pslverr,
        .i_prog_word, .o_table_addr, .o_pc, .o_dummy_cycle);

    task automatic ck(input logic [7:0] g, input logic [7:0] e);
        comparisons++;
        if (g !== e) begin
            errors++;
            $display("BAD %0t got %h want %h", $time, g, e);
        end
    endtask

    // The request stands until ready is seen high at a rising edge; read
    // data is taken at that edge. Only the watchdog ends an endless wait.
    task automatic bus(input logic w, input logic [7:0] idx,
                       input logic [7:0] d);
        @(posedge i_core_clk);
        i_psel    <= 1'b1;
        i_penable <= 1'b0;
        i_pwrite  <= w;
        i_paddr   <= {22'h000000, idx, 2'h0};
        i_pwdata  <= {24'h000000, d};
        @(posedge i_core_clk);
        i_penable <= 1'b1;
        do begin
            @(posedge i_core_clk);
        end while (o_pready !== 1'b1);
        q = o_prdata[7:0];
        ck({7'h00, o_pslverr}, 8'h00);
        i_psel    <= 1'b0;
        i_penable <= 1'b0;
    endtask

    task automatic wr(input logic [7:0] idx, input logic [7:0] d);
        bus(1'b1, idx, d);
    endtask

    task automatic rd(input logic [7:0] idx, input logic [7:0] e);
        bus(1'b0, idx, 8'h00);
        ck(q, e);
    endtask

    task automatic alu(input logic [3:0] o, input logic [7:0] a, b, r, f);
        wr(`ADDR_WORKING_REG, a);
        wr(`ADDR_OP_ARG, b);
        wr(`ADDR_OP_CTRL, {4'h0, o});
        rd(`ADDR_WORKING_REG, r);
        rd(`ADDR_CORE_FLAGS, f);
    endtask

    task automatic t_arith;
        logic [7:0] va [5] = '{8'h0F, 8'h7F, 8'hFF, 8'h80, 8'h01};
        logic [7:0] vb [5] = '{8'h01, 8'h01, 8'h01, 8'h01, 8'h02};
        logic [7:0] a;
        logic [7:0] b;
        logic [8:0] s;
        logic [7:0] r;
        logic [7:0] f;
        for (int i = 0; i < 5; i++) begin
            a = va[i];
            b = vb[i];
            s = a + b;
            r = s[7:0];
            f = {4'h0, ~(a[7] ^ b[7]) & (s[7] ^ a[7]), r == 8'h00,
                 ({1'b0, a[3:0]} + {1'b0, b[3:0]}) > 5'h0F, s[8]};
            alu(`OP_ADD, a, b, r, f);
            s = a - b;
            r = s[7:0];
            f = {4'h0, (a[7] ^ b[7]) & (s[7] ^ a[7]), r == 8'h00,
                 a[3:0] >= b[3:0], a >= b};
            alu(`OP_SUB, a, b, r, f);
        end
        $display("arith done");
    endtask

    task automatic t_logic;
        wr(`ADDR_CORE_FLAGS, 8'h0B);
        alu(`OP_AND, 8'hF0, 8'h0F, 8'h00, 8'h0F);
        alu(`OP_OR, 8'h50, 8'h05, 8'h55, 8'h0B);
        alu(`OP_XOR, 8'h55, 8'h55, 8'h00, 8'h0F);
        alu(`OP_RLC, 8'h81, 8'h00, 8'h03, 8'h0F);
        alu(`OP_RRC, 8'h02, 8'h00, 8'h81, 8'h0E);
        alu(`OP_RLC, 8'h80, 8'h00, 8'h00, 8'h0F);
        alu(`OP_LOAD, 8'h12, 8'hA4, 8'hA4, 8'h0F);
        $display("logic done");
    endtask

    task automatic t_status;
        rd(`ADDR_CORE_FLAGS, 8'h00);
        wr(`ADDR_CORE_FLAGS, 8'hFF);
        rd(`ADDR_CORE_FLAGS, 8'h0F);
        wr(`ADDR_OP_CTRL, {4'h0, `OP_TIMEOUT});
        rd(`ADDR_CORE_FLAGS, 8'h2F);
        wr(`ADDR_CORE_FLAGS, 8'h00);
        rd(`ADDR_CORE_FLAGS, 8'h20);
        wr(`ADDR_OP_CTRL, {4'h0, `OP_HALT});
        rd(`ADDR_CORE_FLAGS, 8'h10);
        wr(`ADDR_OP_CTRL, {4'h0, `OP_TIMEOUT});
        wr(`ADDR_CORE_FLAGS, 8'hC0);
        rd(`ADDR_CORE_FLAGS, 8'h30);
        wr(`ADDR_OP_CTRL, {4'h0, `OP_CLRWDT});
        rd(`ADDR_CORE_FLAGS, 8'h00);
        $display("status done");
    endtask

    task automatic t_jump;
        wr(`ADDR_PC_HIGH, 8'h12);
        wr(`ADDR_PROG_PTR_LOW, 8'h34);
        // Outputs launched by the completing edge are looked at one edge on
        @(posedge i_core_clk);
        ck(o_pc[15:8], 8'h12);
        ck(o_pc[7:0], 8'h34);
        ck({7'h00, o_dummy_cycle}, 8'h01);
        @(posedge i_core_clk);
        ck({7'h00, o_dummy_cycle}, 8'h00);
        wr(`ADDR_PROG_PTR_LOW, 8'hFF);
        @(posedge i_core_clk);
        ck(o_pc[15:8], 8'h12);
        ck(o_pc[7:0], 8'hFF);
        rd(`ADDR_PROG_PTR_LOW, 8'hFF);
        $display("jump done");
    endtask

    task automatic t_table;
        wr(`ADDR_LOOKUP_POINTER, 8'h5A);
        @(posedge i_core_clk);
        ck(o_table_addr, 8'h5A);
        wr(`ADDR_OP_CTRL, {4'h0, `OP_TABRD});
        rd(`ADDR_LOOKUP_HIGH_BYTE, 8'hA5);
        rd(`ADDR_PROG_WORD, 8'h5A);
        rd(`ADDR_WORKING_REG, 8'h5A);
        wr(`ADDR_OP_CTRL, {4'h0, `OP_INC_PTR});
        @(posedge i_core_clk);
        ck(o_table_addr, 8'h5B);
        wr(`ADDR_OP_CTRL, {4'h0, `OP_DEC_PTR});
        wr(`ADDR_OP_CTRL, {4'h0, `OP_DEC_PTR});
        wr(`ADDR_OP_CTRL, {4'h0, `OP_TABRD});
        rd(`ADDR_LOOKUP_HIGH_BYTE, 8'hA6);
        $display("table done");
    endtask

    task automatic t_indirect;
        wr(`ADDR_INDIRECT_POINTER, 8'h03);
        wr(`ADDR_RAM_DATA, 8'h77);
        wr(`ADDR_INDIRECT_POINTER, 8'h04);
        wr(`ADDR_RAM_DATA, 8'h88);
        wr(`ADDR_INDIRECT_PORT, 8'h99);
        rd(`ADDR_INDIRECT_PORT, 8'h00);
        rd(`ADDR_RAM_DATA, 8'h88);
        wr(`ADDR_INDIRECT_POINTER, 8'h03);
        rd(`ADDR_RAM_DATA, 8'h77);
        wr(8'h02, 8'h5A);
        rd(8'h02, 8'h00);
        rd(8'h09, 8'h00);
        $display("indirect done");
    endtask

    task automatic end_of_test;
        $display("errors %0d comparisons %0d", errors, comparisons);
        if (errors == 0 && comparisons > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    initial begin
        repeat (6) @(posedge i_core_clk);
        i_rst <= 1'b0;
        t_status;
        t_arith;
        t_logic;
        t_jump;
        t_table;
        t_indirect;
        end_of_test;
    end

    // About 130 transfers of three or five cycles; allow about twenty-five times
    initial begin
        #100000;
        errors++;
        $display("BAD %0t watchdog expired", $time);
        end_of_test;
    end
endmodule // core_sfr_test
`default_nettype wire
